// ### sac_cfg.svh
// Timing counts, register offsets and reset values for the converter control block.
// Assumes a 100 MHz core clock.
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH
`define SAC_CLK_PERIOD_NS      10
`define SAC_CONV_TIME_NS       322
`define SAC_CONV_CYCLES        (`SAC_CONV_TIME_NS / `SAC_CLK_PERIOD_NS)
`define SAC_POR_WAIT_NS        20000
`define SAC_POR_WAIT_CYCLES    (`SAC_POR_WAIT_NS / `SAC_CLK_PERIOD_NS)
`define SAC_DGC_LOW_PCT        10
`define SAC_DGC_HIGH_PCT       90
`define SAC_REG_CTRL           4'h0
`define SAC_REG_STATUS         4'h4
`define SAC_REG_RESULT         4'h8
`define SAC_REG_SAMPLE         4'hC
`define SAC_CTRL_RESET         32'h0000_0000
`define SAC_CTRL_CHAIN_BIT     0
`define SAC_STAT_BUSY_BIT      0
`define SAC_STAT_READY_BIT     1
`define SAC_STAT_DGC_BIT       2
`define SAC_STAT_PWRDN_BIT     3
`endif

// ### sac_checker.sv
// Assertions on the converter pins of sac_top.
// Assumes it is bound into sac_top and shares its POR wait count.
`timescale 1ns/1ps
module sac_checker #(
	parameter int POR_WAIT_CYCLES = 2000
) (
	// Clock and reset
	input wire logic        core_clk_in,
	input wire logic        nrst_in,
	// Converter pins
	input wire logic        conversion_start_in,
	input wire logic        sck_in,
	input wire logic        read_select_or_chain_input_in,
	input wire logic        ref_compress_select_in,
	input wire logic [15:0] sample_in,
	input wire logic        busy_out,
	input wire logic        sdo_out,
	input wire logic        sdo_oe_out
);
	logic [5:0]  bcnt;
	logic [15:0] pcnt;
	logic [3:0]  scnt;
	logic        sck_q;
	// Busy length, age since reset, age of last raw shift edge
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bcnt  <= 6'h00;
			pcnt  <= 16'h0000;
			scnt  <= 4'hF;
			sck_q <= 1'b0;
		end else begin
			bcnt  <= busy_out ? bcnt + 6'h01 : 6'h00;
			pcnt  <= (pcnt == 16'hFFFF) ? pcnt : pcnt + 16'h0001;
			scnt  <= (sck_in && !sck_q) ? 4'h0 : ((scnt == 4'hF) ? scnt : scnt + 4'h1);
			sck_q <= sck_in;
		end
	end
	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	busy_len_a: assert property ($fell(busy_out) |-> bcnt == 6'h20)
		else $error("busy length");
	conv_time_a: assert property (busy_out |-> bcnt < 6'h20)
		else $error("conversion too long");
	start_a: assert property ($rose(busy_out) |-> $past(conversion_start_in, 3))
		else $error("busy without start");
	por_a: assert property (busy_out |-> int'(pcnt) >= POR_WAIT_CYCLES)
		else $error("busy in POR wait");
	rest_a: assert property ($fell(busy_out) |-> !busy_out [*3])
		else $error("no power down");
	msb_a: assert property ($fell(busy_out) && ref_compress_select_in |-> sdo_out == sample_in[15])
		else $error("msb not at busy fall");
	oe_a: assert property (!read_select_or_chain_input_in [*5] |-> sdo_oe_out)
		else $error("sdo not enabled");
	shift_a: assert property ($changed(sdo_out) |-> scnt < 4'h8 || $fell(busy_out))
		else $error("sdo moved without shift");
	cover property ($fell(busy_out));
	cover property ($changed(sdo_out) && !busy_out);
	cover property (!sdo_oe_out);
endmodule : sac_checker
bind sac_top sac_checker #(.POR_WAIT_CYCLES(POR_WAIT_CYCLES)) u_sac_checker (.*);

// ### sac_host.sv
// Host model: start pulses, shift clock and select line.
// Assumes tasks are called one at a time from the bench.
`timescale 1ns/1ps
module sac_host (
	// Clock
	input  wire logic clk_in,
	// Converter pins
	input  wire logic sdo_in,
	output logic      cnv_out,
	output logic      sck_out,
	output logic      rsel_out
);
	initial begin
		cnv_out  = 1'b0;
		sck_out  = 1'b0;
		rsel_out = 1'b1;
	end
	task automatic convert();
		@(posedge clk_in);
		cnv_out <= 1'b1;
		repeat (2) @(posedge clk_in);
		cnv_out <= 1'b0;
	endtask : convert
	task automatic sel(input logic lvl);
		@(posedge clk_in);
		rsel_out <= lvl;
		repeat (6) @(posedge clk_in);
	endtask : sel
	// Shift clock runs only inside the frame, 125 ns period
	task automatic shift(input int n, output logic [32:0] q);
		q = '0;
		for (int i = 0; i < n; i++) begin
			q = {q[31:0], sdo_in};
			#62.5 sck_out = 1'b1;
			#62.5 sck_out = 1'b0;
		end
		repeat (17) @(posedge clk_in);
	endtask : shift
endmodule : sac_host

// ### sac_pkg.sv
// Types shared by the converter control block.
// Assumes sac_cfg.svh is on the include path.
package sac_pkg;
	typedef enum logic [2:0] {
		SAC_ST_INIT  = 3'b001,
		SAC_ST_IDLE  = 3'b010,
		SAC_ST_CONV  = 3'b100
	} sac_state_t;

	typedef struct packed {
		logic        read_n;
		logic        write_n;
	} sac_dummy_t;

	typedef struct packed {
		sac_state_t  state;
		logic [15:0] count;
		logic [15:0] result;
		logic [15:0] shreg;
		logic [4:0]  shifted;
		logic        sdo;
		logic        chain;
		logic        por_done;
		logic        cnv_s2;
		logic        cnv_s3;
		logic        sck_s2;
		logic        sck_s3;
		logic        rsel_s2;
		logic        rsel_s3;
		logic        dgc_s2;
		logic        dgc_s3;
		logic [31:0] rdata;
		logic        rvalid;
		logic [15:0] sample;
	} sac_state_reg_t;
endpackage : sac_pkg

// ### sac_top.sv
// Converter control and serial readout of a 16-bit SAR converter with Avalon-MM registers.
// Assumes pins are asynchronous to core_clk_in and that the analog code arrives on sample_in.
//
// Operation
// - Compression maps codes to 10-90% swing
// - Internal reset at power-up and brownout; here only nrst_in low starts it, no brownout sensing
// - Start rising edge begins conversion, wakes device
// - Start requests ignored during running conversion
// - Busy high exactly during conversion
// - After conversion power down, resume acquiring
// - Conversion finishes 32 cycles (320ns) after busy rises, which is 2 cycles after start is sampled
// - Previous result shiftable while powered down
// - Shift only when enabled and clock toggles
// - Output bit updates on shift rising edge
// - Result msb holds until first rising edge
// - Result is 16-bit twos complement code
// - Normal mode: drive when select low
// - Msb presented at busy falling edge
// - Chain mode: always driven, shifts upstream in
`timescale 1ns/1ps
`include "sac_cfg.svh"

module sac_top
	import sac_pkg::*;
#(
	parameter int POR_WAIT_CYCLES = `SAC_POR_WAIT_CYCLES
) (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        nrst_in,
	// Converter pins
	input  wire logic        conversion_start_in,
	input  wire logic        sck_in,
	input  wire logic        read_select_or_chain_input_in,
	input  wire logic        ref_compress_select_in,
	output logic             busy_out,
	output logic             sdo_out,
	output logic             sdo_oe_out,
	// Raw comparator result, two's complement
	input  wire logic [15:0] sample_in,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);

	// ************************************************************
	// State and first synchroniser stage
	// ************************************************************
	sac_state_reg_t r;
	sac_state_reg_t next_r;
	logic           cnv_s1;
	logic           sck_s1;
	logic           rsel_s1;
	logic           dgc_s1;

	localparam logic [15:0] CONV_CYCLES = 16'(`SAC_CONV_CYCLES);
	localparam logic [15:0] POR_CYCLES  = 16'(POR_WAIT_CYCLES);

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnv_s1  <= 1'b0;
			sck_s1  <= 1'b0;
			rsel_s1 <= 1'b1;
			dgc_s1  <= 1'b1;
		end else begin
			cnv_s1  <= conversion_start_in;
			sck_s1  <= sck_in;
			rsel_s1 <= read_select_or_chain_input_in;
			dgc_s1  <= ref_compress_select_in;
		end
	end

	// ************************************************************
	// Gain compression scaling
	// ************************************************************
	// Offset code is 0..65535; compressed = low + code*(high-low)/100
	function automatic logic [15:0] sac_compress(input logic [15:0] code);
		logic [31:0] ofs;
		logic [31:0] scaled;
		ofs    = {16'h0000, code ^ 16'h8000};
		scaled = (32'(`SAC_DGC_LOW_PCT) * 32'h0000_FFFF) / 32'd100
			+ (ofs * 32'(`SAC_DGC_HIGH_PCT - `SAC_DGC_LOW_PCT)) / 32'd100;
		return scaled[15:0] ^ 16'h8000;
	endfunction : sac_compress

	// ************************************************************
	// Next state
	// ************************************************************
	logic cnv_rise;
	logic sck_rise;
	logic sdo_en;
	logic reg_wr;

	always_comb begin
		next_r         = r;
		next_r.cnv_s2  = cnv_s1;
		next_r.cnv_s3  = r.cnv_s2;
		next_r.sck_s2  = sck_s1;
		next_r.sck_s3  = r.sck_s2;
		next_r.rsel_s2 = rsel_s1;
		next_r.rsel_s3 = r.rsel_s2;
		next_r.dgc_s2  = dgc_s1;
		next_r.dgc_s3  = r.dgc_s2;
		cnv_rise       = r.cnv_s2 && !r.cnv_s3;
		sck_rise       = r.sck_s2 && !r.sck_s3;
		sdo_en         = r.chain || !r.rsel_s3;
		reg_wr         = avs_write && avs_byteenable[0] && (avs_address == `SAC_REG_CTRL);
		next_r.rvalid  = avs_read && !r.rvalid;

		unique case (r.state)
			SAC_ST_INIT: begin
				// Internal reset wait after power-on; start edges ignored
				if (r.count >= POR_CYCLES - 16'h0001) begin
					next_r.state    = SAC_ST_IDLE;
					next_r.por_done = 1'b1;
					next_r.count    = 16'h0000;
				end else begin
					next_r.count = r.count + 16'h0001;
				end
			end
			SAC_ST_IDLE: begin
				// Powered down and acquiring until a start edge
				if (cnv_rise) begin
					next_r.state  = SAC_ST_CONV;
					next_r.count  = 16'h0000;
					next_r.sample = sample_in;
				end
			end
			SAC_ST_CONV: begin
				// Further start edges are not looked at here
				if (r.count >= CONV_CYCLES - 16'h0001) begin
					next_r.state   = SAC_ST_IDLE;
					next_r.count   = 16'h0000;
					next_r.result  = r.dgc_s3 ? r.sample : sac_compress(r.sample);
					next_r.shreg   = next_r.result;
					next_r.sdo     = next_r.result[15];
					next_r.shifted = 5'h00;
				end else begin
					next_r.count = r.count + 16'h0001;
				end
			end
		endcase

		// Shifting runs in any state except the last conversion cycle, so the held result is readable powered down
		if (sck_rise && sdo_en && !(r.state == SAC_ST_CONV && r.count >= CONV_CYCLES - 16'h0001)) begin
			if (r.chain) begin
				next_r.shreg = {r.shreg[14:0], r.rsel_s3};
				next_r.sdo   = r.shreg[14];
			end else if (r.shifted >= 5'd15) begin
				next_r.shreg   = 16'h0000;
				next_r.sdo     = 1'b0;
				next_r.shifted = 5'd16;
			end else begin
				next_r.shreg   = {r.shreg[14:0], 1'b0};
				next_r.sdo     = r.shreg[14];
				next_r.shifted = r.shifted + 5'h01;
			end
		end

		if (reg_wr) begin
			next_r.chain = avs_writedata[`SAC_CTRL_CHAIN_BIT];
		end

		next_r.rdata = 32'h0000_0000;
		unique case (avs_address)
			`SAC_REG_CTRL: next_r.rdata[`SAC_CTRL_CHAIN_BIT] = r.chain;
			`SAC_REG_STATUS: begin
				next_r.rdata[`SAC_STAT_BUSY_BIT]  = (r.state == SAC_ST_CONV);
				next_r.rdata[`SAC_STAT_READY_BIT] = r.por_done;
				next_r.rdata[`SAC_STAT_DGC_BIT]   = !r.dgc_s3;
				next_r.rdata[`SAC_STAT_PWRDN_BIT] = (r.state != SAC_ST_CONV);
			end
			`SAC_REG_RESULT: next_r.rdata[15:0] = r.result;
			`SAC_REG_SAMPLE: next_r.rdata[15:0] = r.shreg;
			default: next_r.rdata = 32'h0000_0000;
		endcase
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r          <= '0;
			r.state    <= SAC_ST_INIT;
			r.rsel_s2  <= 1'b1;
			r.rsel_s3  <= 1'b1;
			r.dgc_s2   <= 1'b1;
			r.dgc_s3   <= 1'b1;
			r.shifted  <= 5'd16;
			r.chain    <= 1'(`SAC_CTRL_RESET);
		end else begin
			r <= next_r;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign busy_out        = (r.state == SAC_ST_CONV);
	assign sdo_out         = r.sdo;
	assign sdo_oe_out      = r.chain || !r.rsel_s3;
	assign avs_readdata    = r.rdata;
	assign avs_waitrequest = avs_read && !r.rvalid;

endmodule : sac_top

// ### sac_top_tb.sv
// Bench for sac_top: host model on the pins, Avalon master on registers.
// Assumes sac_host and sac_checker are compiled first.
`timescale 1ns/1ps
module sac_top_tb;
	logic        clk = 1'b0;
	logic        nrst;
	logic        cps;
	logic        rd;
	logic        wr;
	logic        waitr;
	logic        ws;
	logic        busy;
	logic        sdo;
	logic        oe;
	logic        conversion_start;
	logic        sck;
	logic        rsel;
	logic [3:0]  addr;
	logic [15:0] smp;
	logic [31:0] wd;
	logic [31:0] rdat;
	logic [31:0] d;
	logic [32:0] q;
	int          n_fail = 0;
	int          compares = 0;
	int          k;
	always #5 clk = ~clk;
	sac_top #(.POR_WAIT_CYCLES(20)) u_sac_top (
		.core_clk_in(clk), .nrst_in(nrst), .conversion_start_in(conversion_start), .sck_in(sck),
		.read_select_or_chain_input_in(rsel), .ref_compress_select_in(cps),
		.busy_out(busy), .sdo_out(sdo), .sdo_oe_out(oe), .sample_in(smp),
		.avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(waitr));
	sac_host u_sac_host (.clk_in(clk), .sdo_in(sdo), .cnv_out(conversion_start), .sck_out(sck),
		.rsel_out(rsel));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [32:0] s, input logic [32:0] e, input string w);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", w, e, s);
		end
	endtask : chk
	task automatic test_done();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task automatic lim();
		if (k == 99) begin
			n_fail++;
			test_done();
		end
	endtask : lim
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wd <= v;
		wr <= w;
		rd <= !w;
		for (k = 0; k < 99; k++) begin
			@(negedge clk);
			ws = waitr;
			d = rdat;
			@(posedge clk);
			if (ws === 1'b0)
				break;
		end
		rd <= 1'b0;
		wr <= 1'b0;
		lim();
	endtask : bus
	task automatic wb(input logic lvl);
		for (k = 0; k < 99; k++) begin
			@(negedge clk);
			if (busy === lvl)
				break;
		end
		lim();
	endtask : wb
	initial begin
		nrst = 1'b0;
		cps = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		addr = 4'h0;
		wd = 32'h0;
		smp = 16'hA5C3;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		u_sac_host.convert();
		repeat (24) @(posedge clk);
		chk(33'(busy), 33'h0, "busy in POR");
		bus(1'b0, 4'h0, 32'h0);
		chk(33'(d), 33'h0, "ctrl reset");
		bus(1'b0, 4'h2, 32'h0);
		chk(33'(d), 33'h0, "unmapped");
		bus(1'b0, 4'h4, 32'h0);
		chk(33'(d[2:0]), 33'h2, "status");
		u_sac_host.convert();
		u_sac_host.convert();
		wb(1'b1);
		wb(1'b0);
		u_sac_host.sel(1'b0);
		chk(33'(oe), 33'h1, "oe low sel");
		u_sac_host.shift(17, q);
		chk(q, {16'h0, 16'hA5C3, 1'b0}, "readout");
		u_sac_host.sel(1'b1);
		chk(33'(oe), 33'h0, "oe high sel");
		smp <= 16'h5A3C;
		u_sac_host.convert();
		wb(1'b1);
		bus(1'b0, 4'h8, 32'h0);
		chk(33'(d[15:0]), 33'hA5C3, "old result");
		wb(1'b0);
		bus(1'b0, 4'h8, 32'h0);
		chk(33'(d[15:0]), 33'h5A3C, "new result");
		cps <= 1'b0;
		u_sac_host.convert();
		wb(1'b1);
		wb(1'b0);
		chk(33'(k), 33'd31, "busy cycles");
		bus(1'b0, 4'h8, 32'h0);
		chk(33'(d[15:0]), 33'h482F, "compressed");
		bus(1'b0, 4'h4, 32'h0);
		chk(33'(d[2]), 33'h1, "compression");
		cps <= 1'b1;
		bus(1'b1, 4'h0, 32'h1);
		bus(1'b0, 4'h0, 32'h0);
		chk(33'(d[0]), 33'h1, "ctrl chain");
		smp <= 16'h1234;
		u_sac_host.convert();
		wb(1'b1);
		wb(1'b0);
		chk(33'(oe), 33'h1, "chain oe");
		u_sac_host.shift(33, q);
		chk(q, {16'h1234, 17'h1FFFF}, "chain");
		test_done();
	end
endmodule : sac_top_tb
